//--- sim/pmr_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pmr_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Frames and settings
  input wire logic frmValid,
  input wire pmr_pkg::pmr_frame_t frmDesc,
  input wire logic macFullDuplex,
  input wire pmr_pkg::pmr_speed_t macSpeed,
  input wire logic txFlowCtrlEn,
  input wire logic rxFlowCtrlEn,
  input wire logic backPressureEn,
  input wire logic stormProtectEn,
  input wire logic [13:0] maxPayload,
  input wire logic verdictValid,
  input wire pmr_pkg::pmr_verdict_t verdict
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // A write that completes at this edge
  sequence wrDone(logic [11:0] a);
    avs_write && !avs_waitrequest && avs_address == a;
  endsequence
  // Exactly one wait cycle per access
  sequence oneWait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> oneWait)
    else $error("bus wait is not one cycle");
  AST_DUPLEX: assert property (
    wrDone(pmr_pkg::OFF_EXT_MODE) |=> macFullDuplex == $past(avs_writedata[6]))
    else $error("duplex does not follow its bit");
  AST_FLOW_EN: assert property (
    wrDone(pmr_pkg::OFF_EXT_MODE) |=> txFlowCtrlEn == $past(avs_writedata[5])
      && rxFlowCtrlEn == $past(avs_writedata[3]))
    else $error("flow enables do not follow their bits");
  AST_GIG: assert property (
    wrDone(pmr_pkg::OFF_EXT_IFCFG) && !avs_writedata[6] |=> macSpeed == pmr_pkg::SPD_1000)
    else $error("gigabit not selected");
  AST_SPD: assert property (
    wrDone(pmr_pkg::OFF_EXT_MODE) && macSpeed != pmr_pkg::SPD_1000
      |=> macSpeed == ($past(avs_writedata[4]) ? pmr_pkg::SPD_100 : pmr_pkg::SPD_10))
    else $error("10/100 speed wrong");
  AST_ACCEPT: assert property (
    wrDone(pmr_pkg::OFF_FRAME_ACC) |=> stormProtectEn == $past(avs_writedata[1])
      && maxPayload == ($past(avs_writedata[0]) ? pmr_pkg::PAYLOAD_JUMBO : pmr_pkg::PAYLOAD_STD))
    else $error("storm or payload limit wrong");
  AST_BP_HALF: assert property (backPressureEn |-> !macFullDuplex)
    else $error("back pressure in full duplex");
  AST_VERDICT: assert property (frmValid |=> verdictValid)
    else $error("verdict missing");
  AST_BAD: assert property (
    frmValid && frmDesc.crcErr && !frmDesc.isFlowCtrl |=> verdict.drop || verdict.mirrorOnly)
    else $error("bad frame forwarded normally");
endmodule // pmr_checker
bind pmr_port_mac_ctrl pmr_checker u_chk (.sys_clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .frmValid, .frmDesc, .macFullDuplex,
  .macSpeed, .txFlowCtrlEn, .rxFlowCtrlEn, .backPressureEn, .stormProtectEn, .maxPayload,
  .verdictValid, .verdict);
`default_nettype wire

//--- sim/pmr_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pmr_link_partner (
  // Clock
  input wire logic sys_clk,
  // Frame request from the bench
  input wire logic sendReq,
  input wire pmr_pkg::pmr_frame_t sendDesc,
  // Ingress toward the port
  output logic frmValid,
  output pmr_pkg::pmr_frame_t frmDesc
);
  initial frmValid = 1'b0;
  initial frmDesc = '0;
  // One-cycle descriptor; idle lines toggle so stale data is never mistaken for a frame
  always @(posedge sys_clk) begin
    frmValid <= sendReq;
    frmDesc <= sendReq ? sendDesc : ~frmDesc;
  end
endmodule // pmr_link_partner
`default_nettype wire

//--- sim/port_mac_ctrl_ingress_rate_limiter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module port_mac_ctrl_ingress_rate_limiter_tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rdv;
  logic avs_waitrequest, frmValid, verdictValid, pauseReq;
  logic sendReq = 1'b0;
  pmr_pkg::pmr_frame_t frmDesc;
  pmr_pkg::pmr_frame_t sendDesc = '0;
  logic macFullDuplex, txFlowCtrlEn, rxFlowCtrlEn, backPressureEn, stormProtectEn;
  pmr_pkg::pmr_speed_t macSpeed;
  logic [13:0] maxPayload;
  pmr_pkg::pmr_verdict_t verdict;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // Rows: address, write data, expected read back
  logic [27:0] rows [10] = '{28'h300_2828, 28'h301_5858, 28'h400_8303, 28'h401_4909,
    28'h403_FF7F, 28'h410_E565, 28'h416_FF7F, 28'h417_8000, 28'h402_FF00, 28'h5FF_FF00};
  // Reset values: address, expected; straps are tied high
  logic [19:0] rstv [7] = '{20'h3_0078, 20'h3_0148, 20'h4_0000, 20'h4_0100, 20'h4_0300,
    20'h4_1000, 20'h4_1700};
  always #5 sys_clk = ~sys_clk;
  pmr_port_mac_ctrl uut (.sys_clk, .srst, .strapFlowCtrl(1'b1), .strapGigOff(1'b1),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .frmValid, .frmDesc, .macFullDuplex, .macSpeed, .txFlowCtrlEn, .rxFlowCtrlEn,
    .rxClockSkewEn(), .txClockSkewEn(), .backPressureEn, .stormProtectEn, .maxPayload,
    .verdictValid, .verdict, .pauseReq);
  pmr_link_partner u_lp (.sys_clk, .sendReq, .sendDesc, .frmValid, .frmDesc);
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    // Only the hang guard ends a wait that never finishes
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic pmr_pkg::pmr_frame_t mk(input logic [13:0] len, input logic [2:0] p,
      input logic [4:0] fl);
    pmr_pkg::pmr_frame_t f;
    f.payloadLen = len;
    f.wireLen = 16'(len) + 16'h0012;
    f.prio = p;
    {f.isBcast, f.isMcast, f.isFlood, f.crcErr, f.isFlowCtrl} = fl;
    return f;
  endfunction
  // Send one frame; e is {mirrorOnly, drop}, 2'b11 means not checked
  task automatic frm(input pmr_pkg::pmr_frame_t f, input logic [1:0] e);
    sendReq <= 1'b1;
    sendDesc <= f;
    @(posedge sys_clk);
    sendReq <= 1'b0;
    @(posedge sys_clk);
    #1 if (e != 2'b11) chk("verdict", 32'({1'b1, e}),
      32'({verdictValid, verdict.mirrorOnly, verdict.drop}));
    @(posedge sys_clk);
  endtask
  task automatic reset_dut();
    srst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    reset_dut();
    foreach (rows[i]) begin
      bus(1'b1, rows[i][27:16], rows[i][15:8]);
      bus(1'b0, rows[i][27:16], 8'h00);
      chk("reg", 32'(rows[i][7:0]), rdv);
    end
    $display("test registers done");
    // Second reset in mid-run restores every value
    reset_dut();
    foreach (rstv[i]) begin
      bus(1'b0, rstv[i][19:8], 8'h00);
      chk("reset", 32'(rstv[i][7:0]), rdv);
    end
    chk("speed", 32'(pmr_pkg::SPD_100), 32'(macSpeed));
    $display("test reset done");
    bus(1'b1, 12'h0301, 8'h00);
    chk("speed", 32'(pmr_pkg::SPD_1000), 32'(macSpeed));
    bus(1'b1, 12'h0300, 8'h68);
    chk("speed", 32'(pmr_pkg::SPD_1000), 32'(macSpeed));
    bus(1'b1, 12'h0301, 8'h40);
    chk("speed", 32'(pmr_pkg::SPD_10), 32'(macSpeed));
    bus(1'b1, 12'h0401, 8'h08);
    chk("bp", 32'h0000_0000, 32'(backPressureEn));
    bus(1'b1, 12'h0300, 8'h38);
    chk("bp", 32'h0000_0001, 32'(backPressureEn));
    chk("duplex", 32'h0000_0000, 32'(macFullDuplex));
    bus(1'b1, 12'h0300, 8'h78);
    chk("speed", 32'(pmr_pkg::SPD_100), 32'(macSpeed));
    $display("test mac mode done");
    // Bad frames, then pass-all and jumbo
    frm(mk(14'd1600, 3'd0, 5'b00000), 2'b01);
    frm(mk(14'd100, 3'd0, 5'b00010), 2'b01);
    frm(mk(14'd100, 3'd0, 5'b00011), 2'b00);
    frm(mk(14'd40, 3'd0, 5'b00000), 2'b01);
    bus(1'b1, 12'h0401, 8'h01);
    frm(mk(14'd100, 3'd0, 5'b00010), 2'b10);
    bus(1'b1, 12'h0400, 8'h03);
    chk("storm", 32'h0000_0001, 32'(stormProtectEn));
    frm(mk(14'd1600, 3'd0, 5'b00000), 2'b00);
    bus(1'b1, 12'h0400, 8'h00);
    bus(1'b1, 12'h0401, 8'h00);
    $display("test frames done");
    // Packet mode; priority 0 code stays pending until the priority 7 write
    bus(1'b1, 12'h0403, 8'h20);
    bus(1'b1, 12'h0410, 8'h01);
    for (int i = 0; i < 4; i++) frm(mk(14'd100, 3'd0, 5'b00000), 2'b00);
    bus(1'b1, 12'h0417, 8'h00);
    for (int i = 0; i < 4; i++) frm(mk(14'd100, 3'd0, 5'b00000), i == 3 ? 2'b01 : 2'b11);
    for (int i = 0; i < 4; i++) frm(mk(14'd100, 3'd3, 5'b00000), 2'b00);
    // Port based: every priority draws on the spent priority 0 budget
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 12'h0403, 8'h60 | 8'(m << 2));
      frm(mk(14'd100, 3'd3, 5'b01000), m < 3 ? 2'b01 : 2'b00);
      frm(mk(14'd100, 3'd3, 5'b00100), m < 2 ? 2'b01 : 2'b00);
    end
    frm(mk(14'd100, 3'd3, 5'b10000), 2'b01);
    bus(1'b1, 12'h0403, 8'h70);
    frm(mk(14'd100, 3'd3, 5'b00000), 2'b00);
    @(posedge sys_clk);
    chk("pause", 32'h0000_0001, 32'(pauseReq));
    $display("test rate limit done");
    results();
  end
endmodule // port_mac_ctrl_ingress_rate_limiter_tb_top
`default_nettype wire

//--- src/pmr_pkg.sv
package pmr_pkg;
  // Register byte addresses within one port's space (N = 0 here)
  localparam logic [11:0] OFF_EXT_MODE = 12'h0300;
  localparam logic [11:0] OFF_EXT_IFCFG = 12'h0301;
  localparam logic [11:0] OFF_FRAME_ACC = 12'h0400;
  localparam logic [11:0] OFF_BP_CTRL = 12'h0401;
  localparam logic [11:0] OFF_LIM_CFG = 12'h0403;
  localparam logic [11:0] OFF_PRIO0 = 12'h0410;
  localparam logic [11:0] OFF_PRIO7 = 12'h0417;
  localparam logic [11:0] OFF_STATUS = 12'h0420;
  // Field positions
  localparam int B_DUPLEX = 6;
  localparam int B_TXFC = 5;
  localparam int B_SPD100 = 4;
  localparam int B_RXFC = 3;
  localparam int B_GIG_OFF = 6;
  localparam int B_RXSKEW = 4;
  localparam int B_TXSKEW = 3;
  localparam int B_STORM = 1;
  localparam int B_JUMBO = 0;
  localparam int B_BP = 3;
  localparam int B_PASSALL = 0;
  localparam int B_PORTBASED = 6;
  localparam int B_PPS = 5;
  localparam int B_LIMFC = 4;
  localparam int B_IFG = 1;
  localparam int B_PRE = 0;
  // Reset values (strap-dependent bits are loaded after reset release)
  localparam logic [7:0] RST_EXT_MODE = 8'h0050;
  localparam logic [7:0] RST_EXT_IFCFG = 8'h0008;
  localparam logic [7:0] RST_ZERO = 8'h0000;
  // Frame sizing and rate accounting
  localparam logic [13:0] PAYLOAD_STD = 14'd1500;
  localparam logic [13:0] PAYLOAD_JUMBO = 14'd9000;
  localparam logic [15:0] IFG_BYTES = 16'd12;
  localparam logic [15:0] PRE_BYTES = 16'd8;
  // Clock and metering window
  localparam int CLK_MHZ = 100;
  localparam int WINDOW_US = 1000;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam logic [6:0] CODE_LIN_MAX = 7'd100;
  localparam logic [6:0] CODE_FINE_MIN = 7'd101;
  localparam logic [6:0] CODE_FINE_MAX = 7'd115;

  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } pmr_speed_t;

  typedef enum logic [1:0] {
    LIM_ALL = 2'b00,
    LIM_BMF = 2'b01,
    LIM_BM = 2'b10,
    LIM_B = 2'b11
  } pmr_limmode_t;

  // Descriptor of one received frame at ingress
  typedef struct packed {
    logic [13:0] payloadLen;
    logic [15:0] wireLen;
    logic [2:0] prio;
    logic isBcast;
    logic isMcast;
    logic isFlood;
    logic crcErr;
    logic isFlowCtrl;
  } pmr_frame_t;

  // Verdict on one frame
  typedef struct packed {
    logic forward;
    logic mirrorOnly;
    logic drop;
  } pmr_verdict_t;
endpackage : pmr_pkg

//--- src/pmr_port_mac_ctrl.sv
// Function
// [RULE1] Duplex bit set gives full duplex, clear half; resets to full.
// [RULE2] In 10/100 mode the speed bit picks 100 when set, else 10.
// [RULE3] Gigabit-disable clear runs 1000 Mb/s; its reset value comes from a strap.
// [RULE4] Separate transmit and receive flow control enables, reset from a strap.
// [RULE5] Storm protection bit enables broadcast storm protection on ingress; resets off.
// [RULE6] Jumbo bit allows 9000-byte payload, otherwise limit is 1500 bytes.
// [RULE7] Back pressure applies only in half duplex; full duplex uses PAUSE.
// [RULE8] Bad frames dropped unless pass-all, then mirrored only; flow control untouched.
// [RULE9] Rate basis bit: port-wide when set, per priority when clear.
// [RULE10] Packet mode counts packets per second, otherwise bits per second.
// [RULE11] With limit flow control and port flow control, assert flow control on excess.
// [RULE12] Limit mode picks all, bcast/mcast/flood, bcast/mcast, or bcast only.
// [RULE13] Gap bit adds twelve gap bytes per frame to the rate count.
// [RULE14] Preamble bit adds eight bytes per frame, ignored in packet mode.
// [RULE15] Eight 7-bit rate codes at consecutive bytes from priority 0, reset zero.
// [RULE16] Codes 0 to 6 stay pending until the priority 7 code is written.
// [RULE17] Code 0 is line rate, 1-100 linear, 101-115 fixed fine rates.
// [RULE18] Without flow control, frames over the rate are discarded.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module pmr_port_mac_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Configuration straps, sampled at reset release
  input wire logic strapFlowCtrl,
  input wire logic strapGigOff,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Ingress frame descriptor, one per cycle
  input wire logic frmValid,
  input wire pmr_pkg::pmr_frame_t frmDesc,
  // Link-side MAC settings
  output logic macFullDuplex,
  output pmr_pkg::pmr_speed_t macSpeed,
  output logic txFlowCtrlEn,
  output logic rxFlowCtrlEn,
  output logic rxClockSkewEn,
  output logic txClockSkewEn,
  output logic backPressureEn,
  output logic stormProtectEn,
  output logic [13:0] maxPayload,
  // Per-frame result, registered
  output logic verdictValid,
  output pmr_pkg::pmr_verdict_t verdict,
  output logic pauseReq
);

  // Registers
  logic [7:0] extMode_r, extIfCfg_r, frameAcc_r, bpCtrl_r, limCfg_r;
  logic [6:0] pend_r [0:6];
  logic [6:0] active_r [0:7];
  logic strapDone_r;
  logic ack_r;
  logic [31:0] rdData_r;
  logic [31:0] winCnt_r;
  logic [31:0] used_r [0:7];
  logic exceeded_r;
  logic verdictValid_r;
  pmr_pkg::pmr_verdict_t verdict_r;
  logic pauseReq_r;

  // Address decode; any byte offset 0x410..0x417 hits one rate code
  // Writes land on the edge where waitrequest is seen low, never on the waited edge
  wire wrEn = avs_write & ack_r;
  wire rdEn = avs_read & ~ack_r;
  wire isPrio = (avs_address >= pmr_pkg::OFF_PRIO0) && (avs_address <= pmr_pkg::OFF_PRIO7);
  wire [2:0] prioIdx = avs_address[2:0];
  wire [7:0] wByte = avs_writedata[7:0];

  // Speed resolution: gig-disable defers to the 10/100 bit
  wire gigOff = extIfCfg_r[pmr_pkg::B_GIG_OFF];
  pmr_pkg::pmr_speed_t spd;
  assign spd = !gigOff ? pmr_pkg::SPD_1000 :                       // [RULE3]
               (extMode_r[pmr_pkg::B_SPD100] ? pmr_pkg::SPD_100 : pmr_pkg::SPD_10); // [RULE2]

  // Rate code decode to allowance per window (bytes, or packets in PPS mode)
  function automatic logic [31:0] codeBudget(input logic [6:0] code,
                                             input pmr_pkg::pmr_speed_t s,
                                             input logic pps);
    logic [31:0] unitB;
    logic [31:0] c;
    unitB = 32'd0;
    c = {25'd0, code};
    if (code == 7'd0) begin
      // Line rate: never limited
      codeBudget = 32'hFFFF_FFFF;
    end else if (code <= pmr_pkg::CODE_LIN_MAX) begin
      if (pps) begin
        codeBudget = (s == pmr_pkg::SPD_1000) ? c * 32'd19200 : c * 32'd1920;
      end else begin
        // Bytes per millisecond window: 1 Mb/s = 125 bytes
        unitB = (s == pmr_pkg::SPD_1000 && code > 7'd10) ? 32'd1250 : 32'd125;
        codeBudget = (s == pmr_pkg::SPD_10 && code > 7'd10) ? 32'd1250 : c * unitB;
      end
      codeBudget = pps ? codeBudget / 32'd1000 : codeBudget;
    end else if (code <= pmr_pkg::CODE_FINE_MAX) begin
      c = {25'd0, code - 7'd100};
      if (pps) begin
        codeBudget = (s == pmr_pkg::SPD_1000) ? c * 32'd640 : c * 32'd64;
        codeBudget = codeBudget / 32'd1000 + 32'd1;
      end else begin
        codeBudget = (s == pmr_pkg::SPD_10) ? c * 32'd8 : c * 32'd80;
      end
    end else begin
      codeBudget = 32'hFFFF_FFFF;
    end
  endfunction // [RULE17]

  // Bus slave: one wait cycle, then acknowledge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdData_r;

  // Read mux of block state
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    case (avs_address)
      pmr_pkg::OFF_EXT_MODE: rdMux = {1'b0, extMode_r[6:3], 3'b000};
      pmr_pkg::OFF_EXT_IFCFG: rdMux = extIfCfg_r;
      pmr_pkg::OFF_FRAME_ACC: rdMux = {6'd0, frameAcc_r[1:0]};
      pmr_pkg::OFF_BP_CTRL: rdMux = {4'd0, bpCtrl_r[3], 2'b00, bpCtrl_r[0]};
      pmr_pkg::OFF_LIM_CFG: rdMux = {1'b0, limCfg_r[6:0]};
      pmr_pkg::OFF_STATUS: rdMux = {5'd0, pauseReq_r, spd};
      default: rdMux = isPrio ? {1'b0, (prioIdx == 3'd7) ? active_r[7] : pend_r[prioIdx]}
                              : 8'h00;
    endcase
  end

  // Control registers and strap capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      extMode_r <= pmr_pkg::RST_EXT_MODE;   // [RULE1]
      extIfCfg_r <= pmr_pkg::RST_EXT_IFCFG;
      frameAcc_r <= pmr_pkg::RST_ZERO;      // [RULE5]
      bpCtrl_r <= pmr_pkg::RST_ZERO;
      limCfg_r <= pmr_pkg::RST_ZERO;        // [RULE9]
      strapDone_r <= 1'b0;
      ack_r <= 1'b0;
      rdData_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (rdEn) rdData_r <= {24'd0, rdMux};
      if (!strapDone_r) begin
        strapDone_r <= 1'b1;
        extMode_r[pmr_pkg::B_TXFC] <= strapFlowCtrl; // [RULE4]
        extMode_r[pmr_pkg::B_RXFC] <= strapFlowCtrl; // [RULE4]
        extIfCfg_r[pmr_pkg::B_GIG_OFF] <= strapGigOff; // [RULE3]
      end else if (wrEn) begin
        case (avs_address)
          pmr_pkg::OFF_EXT_MODE: extMode_r <= {1'b0, wByte[6:3], 3'b000};
          pmr_pkg::OFF_EXT_IFCFG: extIfCfg_r <= wByte;
          pmr_pkg::OFF_FRAME_ACC: frameAcc_r <= {6'd0, wByte[1:0]};
          pmr_pkg::OFF_BP_CTRL: bpCtrl_r <= {4'd0, wByte[3], 2'b00, wByte[0]};
          pmr_pkg::OFF_LIM_CFG: limCfg_r <= {1'b0, wByte[6:0]};
          default: ;
        endcase
      end
    end
  end

  // Rate code shadow: lower codes pending, priority 7 write commits all
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gPend
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          pend_r[g] <= 7'd0;                // [RULE15]
          active_r[g] <= 7'd0;
        end else begin
          if (wrEn && isPrio && prioIdx == 3'(g)) pend_r[g] <= wByte[6:0]; // [RULE15]
          if (wrEn && isPrio && prioIdx == 3'd7) begin
            // Commit uses the pending value, so a torn update never goes live
            active_r[g] <= pend_r[g];       // [RULE16]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (srst) active_r[7] <= 7'd0;
    else if (wrEn && isPrio && prioIdx == 3'd7) active_r[7] <= wByte[6:0]; // [RULE16]
  end

  // Static MAC settings
  assign macFullDuplex = extMode_r[pmr_pkg::B_DUPLEX];         // [RULE1]
  assign macSpeed = spd;
  assign txFlowCtrlEn = extMode_r[pmr_pkg::B_TXFC];            // [RULE4]
  assign rxFlowCtrlEn = extMode_r[pmr_pkg::B_RXFC];            // [RULE4]
  assign rxClockSkewEn = extIfCfg_r[pmr_pkg::B_RXSKEW];
  assign txClockSkewEn = extIfCfg_r[pmr_pkg::B_TXSKEW];
  assign backPressureEn = bpCtrl_r[pmr_pkg::B_BP] & ~macFullDuplex; // [RULE7]
  assign stormProtectEn = frameAcc_r[pmr_pkg::B_STORM];       // [RULE5]
  assign maxPayload = frameAcc_r[pmr_pkg::B_JUMBO] ? pmr_pkg::PAYLOAD_JUMBO
                                                   : pmr_pkg::PAYLOAD_STD; // [RULE6]

  // Limiter configuration fields
  wire portBased = limCfg_r[pmr_pkg::B_PORTBASED];
  wire ppsMode = limCfg_r[pmr_pkg::B_PPS];
  wire limFc = limCfg_r[pmr_pkg::B_LIMFC];
  pmr_pkg::pmr_limmode_t limMode;
  assign limMode = pmr_pkg::pmr_limmode_t'(limCfg_r[3:2]);

  // Frame classification against the limit mode
  logic counted;
  always_comb begin
    case (limMode)
      pmr_pkg::LIM_ALL: counted = 1'b1;
      pmr_pkg::LIM_BMF: counted = frmDesc.isBcast | frmDesc.isMcast | frmDesc.isFlood;
      pmr_pkg::LIM_BM: counted = frmDesc.isBcast | frmDesc.isMcast;
      pmr_pkg::LIM_B: counted = frmDesc.isBcast;
      default: counted = 1'b1;
    endcase
  end // [RULE12]

  // Per-frame cost: one packet, or bytes plus optional overheads
  wire [15:0] ifgAdd = limCfg_r[pmr_pkg::B_IFG] ? pmr_pkg::IFG_BYTES : 16'd0;    // [RULE13]
  wire [15:0] preAdd = limCfg_r[pmr_pkg::B_PRE] ? pmr_pkg::PRE_BYTES : 16'd0;    // [RULE14]
  wire [31:0] cost = ppsMode ? 32'd1 : {16'd0, frmDesc.wireLen + ifgAdd + preAdd}; // [RULE10]

  // Bucket selection: priority 0 slot serves the whole port when port based, else the frame's priority slot
  wire [2:0] bkt = portBased ? 3'd0 : frmDesc.prio;             // [RULE9]
  wire [31:0] budget = codeBudget(active_r[bkt], spd, ppsMode);
  wire [32:0] newUsed = {1'b0, used_r[bkt]} + {1'b0, cost};
  wire over = counted && (active_r[bkt] != 7'd0) && (newUsed > {1'b0, budget});
  wire isBad = frmDesc.crcErr | (frmDesc.payloadLen > maxPayload)
             | (frmDesc.wireLen < 16'd64);
  wire fcOn = limFc & txFlowCtrlEn;                             // [RULE11]
  wire winEnd = (winCnt_r == 32'(pmr_pkg::WINDOW_CYC - 1));

  // Usage buckets, cleared at every window boundary
  generate
    for (g = 0; g < 8; g = g + 1) begin : gUse
      always_ff @(posedge sys_clk) begin
        if (srst || winEnd) used_r[g] <= 32'd0;
        else if (frmValid && counted && !over && bkt == 3'(g) && !(isBad && !frmDesc.isFlowCtrl))
          used_r[g] <= newUsed[31:0];
      end
    end
  endgenerate

  // Verdict and pause request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      winCnt_r <= 32'd0;
      exceeded_r <= 1'b0;
      verdictValid_r <= 1'b0;
      verdict_r <= '0;
      pauseReq_r <= 1'b0;
    end else begin
      winCnt_r <= winEnd ? 32'd0 : winCnt_r + 32'd1;
      verdictValid_r <= frmValid;
      if (frmValid) begin
        if (isBad && !frmDesc.isFlowCtrl) begin
          // Pass-all lets bad frames reach the mirror port only
          verdict_r <= bpCtrl_r[pmr_pkg::B_PASSALL] ? 3'b010 : 3'b001; // [RULE8]
        end else if (over && !fcOn) begin
          verdict_r <= 3'b001;               // [RULE18]
        end else begin
          verdict_r <= 3'b100;
        end
      end
      // Pause held until the metering window rolls over
      // An excess in the roll-over cycle wins over the clear
      if (frmValid && over && fcOn) exceeded_r <= 1'b1; // [RULE11]
      else if (winEnd) exceeded_r <= 1'b0;
      pauseReq_r <= exceeded_r & fcOn;
    end
  end

  assign verdictValid = verdictValid_r;
  assign verdict = verdict_r;
  assign pauseReq = pauseReq_r;

endmodule // pmr_port_mac_ctrl
`default_nettype wire
